// [hw/eag_pkg.sv]
package eag_pkg;

  // ************************************************************
  // addressing modes
  // ************************************************************
  typedef enum logic [3:0] {
    EAG_OPCODE_ONLY_MODE = 4'h0,
    EAG_LITERAL_OPERAND_MODE = 4'h1,
    EAG_SHORT_ABSOLUTE_MODE = 4'h2,
    EAG_LONG_ABSOLUTE_MODE = 4'h3,
    EAG_POINTER_NO_OFFSET_MODE = 4'h4,
    EAG_POINTER_BYTE_OFFSET_MODE = 4'h5,
    EAG_POINTER_WORD_OFFSET_MODE = 4'h6,
    EAG_BRANCH_OFFSET_MODE = 4'h7,
    EAG_BIT_MODIFY_MODE = 4'h8,
    EAG_BIT_TEST_BRANCH_MODE = 4'h9
  } eag_mode_e;

  // ************************************************************
  // constants
  // ************************************************************
  localparam logic [15:0] EAG_PC_STEP_1 = 16'h0001;
  localparam logic [15:0] EAG_PC_STEP_2 = 16'h0002;
  localparam logic [15:0] EAG_PC_STEP_3 = 16'h0003;
  localparam logic [7:0] EAG_ZERO_BYTE = 8'h00;
  localparam logic [15:0] EAG_PC_RESET = 16'h0000;
  localparam int EAG_BITNUM_LSB = 1;
  localparam int EAG_POLARITY_BIT = 0;

  // ************************************************************
  // request and result carriers
  // ************************************************************
  typedef struct packed {
    eag_mode_e mode;
    logic [7:0] opcode;
    logic [15:0] pc;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] pointer;
    logic branch_cond;
    logic [7:0] tested_data;
    logic [7:0] flags;
  } eag_req_s;

  typedef struct packed {
    logic [15:0] operand_location;
    logic [15:0] next_pc;
    logic branch_taken;
    logic [7:0] condition_flags;
  } eag_res_s;

endpackage

// [hw/eag_add16.sv]
module eag_add16
  import eag_pkg::*;
(
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  output logic [15:0] o_sum
);

  // carries past bit fifteen drop off: 16-bit address space wraps
  assign o_sum = i_a + i_b;

endmodule // eag_add16

// [hw/eag_effective_address_generator.sv]
// Notes on behaviour
// - opcode only: one byte, pc plus one
// - literal: location pc+1, pc plus two
// - short absolute: zero high, byte1 low
// - long absolute: byte1:byte2, pc plus three
// - pointer no offset: zero high, pointer low
// - pointer plus byte1, carry high, pc+2
// - byte1:byte2 plus pointer, pc plus three
// - branch: pc+2 plus signed offset if taken
// - bit modify: zero high, byte1 low, pc+2
// - bit test branch: pc+3 plus offset on match
// - bit test branch: tested bit copied to carry flag, taken or not
module eag_effective_address_generator
  import eag_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire eag_req_s i_req,
  output logic o_valid,
  output eag_res_s o_res
);

  // ************************************************************
  // combinational address forming
  // ************************************************************
  logic [15:0] ptr_ext;
  logic [15:0] word_ofs;
  logic [15:0] ptr_word_sum;
  logic [15:0] ptr_byte_sum;
  logic [15:0] br_base;
  logic [15:0] br_ofs;
  logic [15:0] br_target;
  logic [15:0] lit_loc;
  logic [2:0] bit_num;
  logic tested_bit;
  logic bit_match;

  assign ptr_ext = {EAG_ZERO_BYTE, i_req.pointer};
  assign word_ofs = {i_req.byte1, i_req.byte2};
  assign bit_num = i_req.opcode[EAG_BITNUM_LSB +: 3];
  assign tested_bit = i_req.tested_data[bit_num];
  // polarity bit low means branch when set
  assign bit_match = tested_bit ^ i_req.opcode[EAG_POLARITY_BIT];

  eag_add16 u_ptr_word
  (
    .i_a(ptr_ext),
    .i_b(word_ofs),
    .o_sum(ptr_word_sum)
  );

  eag_add16 u_ptr_byte
  (
    .i_a(ptr_ext),
    .i_b({EAG_ZERO_BYTE, i_req.byte1}),
    .o_sum(ptr_byte_sum)
  );

  eag_add16 u_lit
  (
    .i_a(i_req.pc),
    .i_b(EAG_PC_STEP_1),
    .o_sum(lit_loc)
  );

  // base is the pc after the instruction: two or three bytes
  assign br_base = (i_req.mode == EAG_BIT_TEST_BRANCH_MODE) ?
                   i_req.pc + EAG_PC_STEP_3 : i_req.pc + EAG_PC_STEP_2;
  assign br_ofs = (i_req.mode == EAG_BIT_TEST_BRANCH_MODE) ?
                  {{8{i_req.byte2[7]}}, i_req.byte2} : {{8{i_req.byte1[7]}}, i_req.byte1};

  eag_add16 u_branch
  (
    .i_a(br_base),
    .i_b(br_ofs),
    .o_sum(br_target)
  );

  // ************************************************************
  // result registers
  // ************************************************************
  eag_res_s res_r;
  eag_res_s res_nxt;
  logic valid_r;
  logic valid_nxt;

  always_comb
  begin
    res_nxt = res_r;
    valid_nxt = i_valid;
    if (i_valid)
    begin
      res_nxt.branch_taken = 1'b0;
      res_nxt.condition_flags = i_req.flags;
      res_nxt.operand_location = 16'h0000;
      unique case (i_req.mode)
        EAG_OPCODE_ONLY_MODE:
        begin
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_1;
        end
        EAG_LITERAL_OPERAND_MODE:
        begin
          res_nxt.operand_location = lit_loc;
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_2;
        end
        EAG_SHORT_ABSOLUTE_MODE:
        begin
          res_nxt.operand_location = {EAG_ZERO_BYTE, i_req.byte1};
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_2;
        end
        EAG_LONG_ABSOLUTE_MODE:
        begin
          res_nxt.operand_location = word_ofs;
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_3;
        end
        EAG_POINTER_NO_OFFSET_MODE:
        begin
          res_nxt.operand_location = ptr_ext;
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_1;
        end
        EAG_POINTER_BYTE_OFFSET_MODE:
        begin
          res_nxt.operand_location = ptr_byte_sum;
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_2;
        end
        EAG_POINTER_WORD_OFFSET_MODE:
        begin
          res_nxt.operand_location = ptr_word_sum;
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_3;
        end
        EAG_BRANCH_OFFSET_MODE:
        begin
          res_nxt.branch_taken = i_req.branch_cond;
          res_nxt.next_pc = i_req.branch_cond ? br_target : br_base;
        end
        EAG_BIT_MODIFY_MODE:
        begin
          res_nxt.operand_location = {EAG_ZERO_BYTE, i_req.byte1};
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_2;
        end
        EAG_BIT_TEST_BRANCH_MODE:
        begin
          res_nxt.operand_location = {EAG_ZERO_BYTE, i_req.byte1};
          res_nxt.branch_taken = bit_match;
          res_nxt.next_pc = bit_match ? br_target : br_base;
          res_nxt.condition_flags[0] = tested_bit;
        end
        default:
        begin
          // illegal mode codes behave as a one-byte no-op
          res_nxt.next_pc = i_req.pc + EAG_PC_STEP_1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      res_r <= '{operand_location: 16'h0000, next_pc: EAG_PC_RESET,
                 branch_taken: 1'b0, condition_flags: 8'h00};
      valid_r <= 1'b0;
    end
    else
    begin
      res_r <= res_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign o_res = res_r;
  assign o_valid = valid_r;

  // ************************************************************
  // checks
  // ************************************************************
  // sampled reset in antecedents: disable iff sees the released value
  property p_opcode_only;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_OPCODE_ONLY_MODE) |=>
      o_valid && o_res.next_pc == $past(i_req.pc) + 16'h0001;
  endproperty
  a_opcode_only: assert property (p_opcode_only) else $error("pc step one wrong");

  property p_literal;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_LITERAL_OPERAND_MODE) |=>
      o_res.operand_location == $past(i_req.pc) + 16'h0001 &&
      o_res.next_pc == $past(i_req.pc) + 16'h0002;
  endproperty
  a_literal: assert property (p_literal) else $error("literal location wrong");

  property p_short_abs;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid &&
      (i_req.mode == EAG_SHORT_ABSOLUTE_MODE || i_req.mode == EAG_BIT_MODIFY_MODE))
      |=> o_res.operand_location[15:8] == 8'h00 &&
      o_res.operand_location[7:0] == $past(i_req.byte1);
  endproperty
  a_short_abs: assert property (p_short_abs) else $error("short location wrong");

  property p_long_abs;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_LONG_ABSOLUTE_MODE) |=>
      o_res.operand_location == {$past(i_req.byte1), $past(i_req.byte2)} &&
      o_res.next_pc == $past(i_req.pc) + 16'h0003;
  endproperty
  a_long_abs: assert property (p_long_abs) else $error("long location wrong");

  property p_ptr_byte;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_POINTER_BYTE_OFFSET_MODE) |=>
      o_res.operand_location <= 16'h01FE &&
      o_res.operand_location == 16'($past(i_req.pointer)) + 16'($past(i_req.byte1));
  endproperty
  a_ptr_byte: assert property (p_ptr_byte) else $error("byte offset sum wrong");

  property p_ptr_word;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_POINTER_WORD_OFFSET_MODE) |=>
      o_res.operand_location == 16'({$past(i_req.byte1), $past(i_req.byte2)} +
      16'($past(i_req.pointer)));
  endproperty
  a_ptr_word: assert property (p_ptr_word) else $error("word offset sum wrong");

  property p_branch;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_BRANCH_OFFSET_MODE && !i_req.branch_cond) |=>
      !o_res.branch_taken && o_res.next_pc == $past(i_req.pc) + 16'h0002;
  endproperty
  a_branch: assert property (p_branch) else $error("untaken branch pc wrong");

  property p_bit_carry;
    @(posedge i_clk) disable iff (i_rst)
    (!i_rst && i_valid && i_req.mode == EAG_BIT_TEST_BRANCH_MODE) |=>
      o_res.condition_flags[0] == $past(tested_bit) &&
      o_res.branch_taken == ($past(tested_bit) != $past(i_req.opcode[0]));
  endproperty
  a_bit_carry: assert property (p_bit_carry) else $error("tested bit carry wrong");

  c_taken_branch: cover property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_req.mode == EAG_BRANCH_OFFSET_MODE && i_req.branch_cond);
  c_bit_taken: cover property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_req.mode == EAG_BIT_TEST_BRANCH_MODE && bit_match);
  c_byte_carry: cover property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_req.mode == EAG_POINTER_BYTE_OFFSET_MODE && ptr_byte_sum[8]);

endmodule // eag_effective_address_generator

// [tb/eag_mem_model.sv]
// ************************************************************
// far-side memory: answers every read in the same cycle
// ************************************************************
module eag_mem_model
(
  input wire logic [15:0] i_addr,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // pattern differs per location, so each bit number sees both values
  assign o_data = i_addr[7:0] ^ 8'hA5;
endmodule // eag_mem_model

// [tb/tb_effective_address_generator.sv]
module tb_effective_address_generator
  import eag_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_valid, o_valid;
  eag_req_s i_req;
  eag_res_s o_res;
  logic [15:0] mem_addr;
  logic [7:0] mem_data;
  int errors, checks;

  eag_effective_address_generator u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
    .i_req(i_req), .o_valid(o_valid), .o_res(o_res));
  eag_mem_model u_mem (.i_addr(mem_addr), .o_data(mem_data));

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input logic [40:0] seen, input logic [40:0] expv);
    checks++;
    if (seen !== expv)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  function automatic eag_req_s mk(eag_mode_e m, logic [7:0] op, logic [15:0] pc,
    logic [7:0] b1, logic [7:0] b2, logic [7:0] ptr, logic c);
    eag_req_s r;
    r = '0;
    r.mode = m;
    r.opcode = op;
    r.pc = pc;
    r.byte1 = b1;
    r.byte2 = b2;
    r.pointer = ptr;
    r.branch_cond = c;
    r.flags = op ^ 8'h5B;
    return r;
  endfunction

  function automatic eag_res_s exp_of(eag_req_s r);
    eag_res_s e;
    logic bitv;
    e = '0;
    e.condition_flags = r.flags;
    e.next_pc = r.pc + 16'h0002;
    bitv = r.tested_data[r.opcode[3:1]];
    case (r.mode)
      EAG_OPCODE_ONLY_MODE: e.next_pc = r.pc + 16'h0001;
      EAG_LITERAL_OPERAND_MODE: e.operand_location = r.pc + 16'h0001;
      EAG_SHORT_ABSOLUTE_MODE, EAG_BIT_MODIFY_MODE: e.operand_location = {8'h00, r.byte1};
      EAG_POINTER_BYTE_OFFSET_MODE: e.operand_location = {8'h00, r.pointer} + {8'h00, r.byte1};
      EAG_BRANCH_OFFSET_MODE:
      begin
        e.branch_taken = r.branch_cond;
        if (r.branch_cond) e.next_pc = e.next_pc + {{8{r.byte1[7]}}, r.byte1};
      end
      EAG_POINTER_NO_OFFSET_MODE:
      begin
        e.operand_location = {8'h00, r.pointer};
        e.next_pc = r.pc + 16'h0001;
      end
      default:
      begin
        e.next_pc = r.pc + 16'h0003;
        if (r.mode > EAG_BIT_TEST_BRANCH_MODE) e.next_pc = r.pc + 16'h0001;
        if (r.mode == EAG_LONG_ABSOLUTE_MODE) e.operand_location = {r.byte1, r.byte2};
        if (r.mode == EAG_POINTER_WORD_OFFSET_MODE)
          e.operand_location = {r.byte1, r.byte2} + {8'h00, r.pointer};
        if (r.mode == EAG_BIT_TEST_BRANCH_MODE)
        begin
          e.operand_location = {8'h00, r.byte1};
          e.branch_taken = bitv ^ r.opcode[0];
          if (e.branch_taken) e.next_pc = e.next_pc + {{8{r.byte2[7]}}, r.byte2};
          e.condition_flags[0] = bitv;
        end
      end
    endcase
    return e;
  endfunction

  // one request, far side supplies the tested byte, answer one cycle later
  task automatic run(input eag_req_s r);
    mem_addr = {8'h00, r.byte1};
    @(posedge i_clk);
    r.tested_data = mem_data;
    i_valid <= 1'b1;
    i_req <= r;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    chk({40'h0, o_valid}, 41'h1);
    chk(o_res, exp_of(r));
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset();
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_valid <= 1'b1;
    i_req <= mk(EAG_LONG_ABSOLUTE_MODE, 8'hC6, 16'h1000, 8'h12, 8'h34, 8'h00, 1'b0);
    @(posedge i_clk);
    i_rst <= 1'b0;
    i_valid <= 1'b0;
    #1;
    chk({40'h0, o_valid}, 41'h0);
    chk(o_res, 41'h0);
  endtask

  task automatic t_absolute();
    run(mk(EAG_OPCODE_ONLY_MODE, 8'h9D, 16'h0100, 8'h12, 8'h34, 8'h56, 1'b0));
    run(mk(EAG_LITERAL_OPERAND_MODE, 8'hA6, 16'hFFFF, 8'h12, 8'h34, 8'h56, 1'b0));
    run(mk(EAG_SHORT_ABSOLUTE_MODE, 8'hB6, 16'h2000, 8'hFF, 8'h34, 8'h56, 1'b0));
    run(mk(EAG_LONG_ABSOLUTE_MODE, 8'hC6, 16'h1000, 8'h12, 8'h34, 8'h56, 1'b0));
    run(mk(EAG_LONG_ABSOLUTE_MODE, 8'hC6, 16'hFFFE, 8'hAB, 8'hCD, 8'h56, 1'b0));
    run(mk(EAG_POINTER_NO_OFFSET_MODE, 8'hF6, 16'h0300, 8'h12, 8'h34, 8'hE7, 1'b0));
  endtask

  task automatic t_pointer();
    run(mk(EAG_POINTER_BYTE_OFFSET_MODE, 8'hE6, 16'h0400, 8'hFF, 8'h00, 8'hFF, 1'b0));
    run(mk(EAG_POINTER_BYTE_OFFSET_MODE, 8'hE6, 16'h0400, 8'h10, 8'h00, 8'h20, 1'b0));
    run(mk(EAG_POINTER_WORD_OFFSET_MODE, 8'hD6, 16'h0500, 8'h12, 8'hF0, 8'h20, 1'b0));
    run(mk(EAG_POINTER_WORD_OFFSET_MODE, 8'hD6, 16'hFFFD, 8'hFF, 8'hFF, 8'h01, 1'b0));
  endtask

  task automatic t_branch();
    logic [7:0] offs [3] = '{8'h7F, 8'h80, 8'h00};
    for (int c = 0; c < 2; c++)
      foreach (offs[i])
        run(mk(EAG_BRANCH_OFFSET_MODE, 8'h26, 16'h8000, offs[i], 8'h00, 8'h00, c[0]));
    run(mk(EAG_BRANCH_OFFSET_MODE, 8'h20, 16'h0001, 8'h80, 8'h00, 8'h00, 1'b1));
  endtask

  task automatic t_bit();
    for (int op = 0; op < 16; op++)
    begin
      run(mk(EAG_BIT_TEST_BRANCH_MODE, op[7:0], 16'h0600, 8'h3C, 8'hF8, 8'h00, 1'b0));
      run(mk(EAG_BIT_TEST_BRANCH_MODE, op[7:0], 16'h0600, 8'hC3, 8'h7F, 8'h00, 1'b0));
      run(mk(EAG_BIT_MODIFY_MODE, op[7:0], 16'h0700, op[7:0], 8'h00, 8'h00, 1'b0));
    end
  endtask

  task automatic t_back_to_back();
    eag_req_s a, b;
    a = mk(EAG_LONG_ABSOLUTE_MODE, 8'hC6, 16'h1000, 8'h12, 8'h34, 8'h00, 1'b0);
    b = mk(EAG_POINTER_NO_OFFSET_MODE, 8'hF6, 16'h2000, 8'h00, 8'h00, 8'h99, 1'b0);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_req <= a;
    @(posedge i_clk);
    i_req <= b;
    #1;
    chk(o_res, exp_of(a));
    chk({40'h0, o_valid}, 41'h1);
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    chk(o_res, exp_of(b));
    @(posedge i_clk);
    #1;
    chk({40'h0, o_valid}, 41'h0);
  endtask

  task automatic print_verdict();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial
  begin
    errors = 0;
    checks = 0;
    i_rst = 1'b1;
    i_valid = 1'b0;
    i_req = '0;
    mem_addr = 16'h0000;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    chk({40'h0, o_valid}, 41'h0);
    chk(o_res, 41'h0);
    t_absolute();
    t_pointer();
    t_branch();
    t_bit();
    t_back_to_back();
    t_reset();
    run(mk(EAG_OPCODE_ONLY_MODE, 8'h9D, 16'h0000, 8'h00, 8'h00, 8'h00, 1'b0));
    run(mk(eag_mode_e'(4'hB), 8'h9D, 16'hFFFF, 8'h12, 8'h34, 8'h56, 1'b0));
    print_verdict();
  end

  initial
  begin
    repeat (2000) @(posedge i_clk);
    errors++;
    print_verdict();
  end
endmodule // tb_effective_address_generator
